// ---- pkg/gpio_irq_cfg.svh ----
// constants for the pin interrupt condition block: pin counts, register indices, reset values
// assumes registers are 16 bits wide and each takes one aligned 32-bit apb word
`ifndef GPIO_IRQ_CFG_SVH
`define GPIO_IRQ_CFG_SVH

// pin counts of the two register halves
`define PIN_COUNT 21
`define LOW_PIN_COUNT 16
`define HIGH_PIN_COUNT 5

// register indices; the byte address is four times the index
`define IDX_STATUS_LOW 10'h088
`define IDX_STATUS_HIGH 10'h08A
`define IDX_ENABLE_LOW 10'h08C
`define IDX_ENABLE_HIGH 10'h08E
`define IDX_TRIG_LOW 10'h090
`define IDX_TRIG_HIGH 10'h092
`define IDX_POL_LOW 10'h094
`define IDX_POL_HIGH 10'h096
`define IDX_HOLD_LOW 10'h098
`define IDX_HOLD_HIGH 10'h09A

// apb address width
`define APB_ADDR_W 12

// reset values of the per-pin vectors
`define RESET_CFG 21'h000000
`define RESET_STATUS 21'h000000

`endif

// ---- pkg/gpio_irq_pkg.sv ----
// types shared by the pin interrupt condition block
// assumes gpio_irq_cfg.svh is on the include path
`include "gpio_irq_cfg.svh"

package gpio_irq_pkg;

  // which register an apb address selects
  typedef enum logic [3:0] {
    REG_NONE,
    REG_STATUS_LOW,
    REG_STATUS_HIGH,
    REG_ENABLE_LOW,
    REG_ENABLE_HIGH,
    REG_TRIG_LOW,
    REG_TRIG_HIGH,
    REG_POL_LOW,
    REG_POL_HIGH,
    REG_HOLD_LOW,
    REG_HOLD_HIGH
  } reg_id_type;

  // per-pin configuration, one bit per pin in each field
  typedef struct packed {
    logic [`PIN_COUNT-1:0] enable;
    logic [`PIN_COUNT-1:0] trigger;
    logic [`PIN_COUNT-1:0] polarity;
    logic [`PIN_COUNT-1:0] hold;
  } pin_cfg_type;

endpackage

// ---- logic/pin_sync.sv ----
// three-stage pin synchroniser with agreement filter and previous-sample register
// assumes pins are asynchronous to pclk; all state freezes while clk_en is low
`timescale 1ns/10ps
`default_nettype none

module pin_sync #(
  parameter int WIDTH = 21
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  input wire logic [WIDTH-1:0] pins,
  output logic [WIDTH-1:0] level_q,
  output logic [WIDTH-1:0] prev_q
);

  logic [WIDTH-1:0] s1_q;
  logic [WIDTH-1:0] s1_d;
  logic [WIDTH-1:0] s2_q;
  logic [WIDTH-1:0] s2_d;
  logic [WIDTH-1:0] s3_q;
  logic [WIDTH-1:0] s3_d;
  logic [WIDTH-1:0] level_d;
  logic [WIDTH-1:0] prev_d;

  // next values: a level counts only once stages two and three agree
  always_comb
  begin
    s1_d = s1_q;
    s2_d = s2_q;
    s3_d = s3_q;
    level_d = level_q;
    prev_d = prev_q;
    if (clk_en)
    begin
      s1_d = pins;
      s2_d = s1_q;
      s3_d = s2_q;
      level_d = (s2_q & s3_q) | (level_q & (s2_q | s3_q));
      prev_d = level_q;
    end
  end

  // registers
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
      level_q <= '0;
      prev_q <= '0;
    end
    else
    begin
      s1_q <= s1_d;
      s2_q <= s2_d;
      s3_q <= s3_d;
      level_q <= level_d;
      prev_q <= prev_d;
    end
  end

endmodule

`default_nettype wire

// ---- logic/gpio_interrupt_condition.sv ----
// pin interrupt condition logic: level/edge detection, hold/through, mask, apb registers
// assumes an apb master on pclk, asynchronous pins, and an interrupt controller taking irq
`timescale 1ns/10ps
`default_nettype none

`include "gpio_irq_cfg.svh"

module gpio_interrupt_condition (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [`APB_ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [`PIN_COUNT-1:0] gpio_in,
  output logic irq
);

  logic [`PIN_COUNT-1:0] level_w;
  logic [`PIN_COUNT-1:0] prev_w;
  logic [`PIN_COUNT-1:0] cond_w;
  logic [`PIN_COUNT-1:0] clr_w;
  logic [`PIN_COUNT-1:0] pend_w;
  logic [`PIN_COUNT-1:0] keep_w;
  logic [`PIN_COUNT-1:0] cleared_w;
  logic [`PIN_COUNT-1:0] latch_w;
  logic [`PIN_COUNT-1:0] thru_w;
  logic [`PIN_COUNT-1:0] status_q;
  logic [`PIN_COUNT-1:0] status_d;
  gpio_irq_pkg::pin_cfg_type cfg_q;
  gpio_irq_pkg::pin_cfg_type cfg_d;
  gpio_irq_pkg::reg_id_type sel_id;
  logic [31:0] prdata_q;
  logic [31:0] prdata_d;
  logic irq_q;
  logic irq_d;
  logic wr_w;
  logic high_w;

  // map an apb byte address onto a register
  function automatic gpio_irq_pkg::reg_id_type decode_reg(input logic [`APB_ADDR_W-1:0] addr);
    gpio_irq_pkg::reg_id_type id;
    id = gpio_irq_pkg::REG_NONE;
    case (addr)
      {`IDX_STATUS_LOW, 2'b00}: id = gpio_irq_pkg::REG_STATUS_LOW;
      {`IDX_STATUS_HIGH, 2'b00}: id = gpio_irq_pkg::REG_STATUS_HIGH;
      {`IDX_ENABLE_LOW, 2'b00}: id = gpio_irq_pkg::REG_ENABLE_LOW;
      {`IDX_ENABLE_HIGH, 2'b00}: id = gpio_irq_pkg::REG_ENABLE_HIGH;
      {`IDX_TRIG_LOW, 2'b00}: id = gpio_irq_pkg::REG_TRIG_LOW;
      {`IDX_TRIG_HIGH, 2'b00}: id = gpio_irq_pkg::REG_TRIG_HIGH;
      {`IDX_POL_LOW, 2'b00}: id = gpio_irq_pkg::REG_POL_LOW;
      {`IDX_POL_HIGH, 2'b00}: id = gpio_irq_pkg::REG_POL_HIGH;
      {`IDX_HOLD_LOW, 2'b00}: id = gpio_irq_pkg::REG_HOLD_LOW;
      {`IDX_HOLD_HIGH, 2'b00}: id = gpio_irq_pkg::REG_HOLD_HIGH;
      default: id = gpio_irq_pkg::REG_NONE;
    endcase
    return id;
  endfunction

  // read one half of a pin vector into a bus word; upper reserved bits are zero
  function automatic logic [31:0] read_half(input logic [`PIN_COUNT-1:0] v, input logic high);
    logic [31:0] r;
    if (high)
      r = {27'h0000000, v[`PIN_COUNT-1:`LOW_PIN_COUNT]};
    else
      r = {16'h0000, v[`LOW_PIN_COUNT-1:0]};
    return r;
  endfunction

  // bits a write touches in one half, honouring the byte strobes
  function automatic logic [`PIN_COUNT-1:0] write_mask(
    input logic [31:0] data,
    input logic [3:0] strb,
    input logic high
  );
    logic [`PIN_COUNT-1:0] m;
    m = '0;
    if (high)
      m[`PIN_COUNT-1:`LOW_PIN_COUNT] = data[`HIGH_PIN_COUNT-1:0] & {5{strb[0]}};
    else
      m[`LOW_PIN_COUNT-1:0] = data[15:0] & {{8{strb[1]}}, {8{strb[0]}}};
    return m;
  endfunction

  // merge a write into one half of a configuration vector
  function automatic logic [`PIN_COUNT-1:0] write_half(
    input logic [`PIN_COUNT-1:0] old,
    input logic [31:0] data,
    input logic [3:0] strb,
    input logic high
  );
    logic [`PIN_COUNT-1:0] lanes;
    lanes = write_mask(32'hFFFFFFFF, strb, high);
    return (old & ~lanes) | write_mask(data, strb, high);
  endfunction

  // synchronised pin levels and their previous samples
  pin_sync #(
    .WIDTH(`PIN_COUNT)
  ) u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .clk_en(clk_en),
    .pins(gpio_in),
    .level_q(level_w),
    .prev_q(prev_w)
  );

  // apb decode: zero wait states while enabled, error on unmapped address
  assign sel_id = decode_reg(paddr);
  assign pready = clk_en;
  assign pslverr = psel & penable & (sel_id == gpio_irq_pkg::REG_NONE);
  assign wr_w = psel & penable & pwrite & clk_en;
  assign high_w = (sel_id == gpio_irq_pkg::REG_STATUS_HIGH) ||
                  (sel_id == gpio_irq_pkg::REG_ENABLE_HIGH) ||
                  (sel_id == gpio_irq_pkg::REG_TRIG_HIGH) ||
                  (sel_id == gpio_irq_pkg::REG_POL_HIGH) ||
                  (sel_id == gpio_irq_pkg::REG_HOLD_HIGH);
  assign prdata = prdata_q;
  assign irq = irq_q;

  // per-pin condition: edge on any change, level by polarity
  assign cond_w = (cfg_q.trigger & (level_w ^ prev_w)) |
                  (~cfg_q.trigger & ~(level_w ^ cfg_q.polarity));

  // write-one-to-clear of the status halves
  assign clr_w = (wr_w && (sel_id == gpio_irq_pkg::REG_STATUS_LOW ||
                           sel_id == gpio_irq_pkg::REG_STATUS_HIGH)) ?
                 write_mask(pwdata, pstrb, high_w) : '0;

  // pending requests reaching the controller
  assign pend_w = status_q & cfg_q.enable;

  // helpers read only by the checks below
  assign keep_w = status_q & cfg_q.hold & ~clr_w;
  assign cleared_w = clr_w & cfg_q.hold & ~cond_w;
  assign latch_w = cond_w & cfg_q.hold;
  assign thru_w = ~cfg_q.hold;

  // configuration register writes
  always_comb
  begin
    cfg_d = cfg_q;
    if (wr_w)
    begin
      case (sel_id)
        gpio_irq_pkg::REG_ENABLE_LOW,
        gpio_irq_pkg::REG_ENABLE_HIGH:
          cfg_d.enable = write_half(cfg_q.enable, pwdata, pstrb, high_w);
        gpio_irq_pkg::REG_TRIG_LOW,
        gpio_irq_pkg::REG_TRIG_HIGH:
          cfg_d.trigger = write_half(cfg_q.trigger, pwdata, pstrb, high_w);
        gpio_irq_pkg::REG_POL_LOW,
        gpio_irq_pkg::REG_POL_HIGH:
          cfg_d.polarity = write_half(cfg_q.polarity, pwdata, pstrb, high_w);
        gpio_irq_pkg::REG_HOLD_LOW,
        gpio_irq_pkg::REG_HOLD_HIGH:
          cfg_d.hold = write_half(cfg_q.hold, pwdata, pstrb, high_w);
        default:
          cfg_d = cfg_q;
      endcase
    end
  end

  // status: hold pins latch and a new condition beats the clear, through pins follow
  always_comb
  begin
    status_d = status_q;
    irq_d = irq_q;
    if (clk_en)
    begin
      status_d = cond_w | (cfg_q.hold & status_q & ~clr_w);
      irq_d = |pend_w;
    end
  end

  // read data is captured in the setup phase, ready for the access phase
  always_comb
  begin
    prdata_d = prdata_q;
    if (clk_en && psel && !penable)
    begin
      case (sel_id)
        gpio_irq_pkg::REG_STATUS_LOW,
        gpio_irq_pkg::REG_STATUS_HIGH:
          prdata_d = read_half(status_q, high_w);
        gpio_irq_pkg::REG_ENABLE_LOW,
        gpio_irq_pkg::REG_ENABLE_HIGH:
          prdata_d = read_half(cfg_q.enable, high_w);
        gpio_irq_pkg::REG_TRIG_LOW,
        gpio_irq_pkg::REG_TRIG_HIGH:
          prdata_d = read_half(cfg_q.trigger, high_w);
        gpio_irq_pkg::REG_POL_LOW,
        gpio_irq_pkg::REG_POL_HIGH:
          prdata_d = read_half(cfg_q.polarity, high_w);
        gpio_irq_pkg::REG_HOLD_LOW,
        gpio_irq_pkg::REG_HOLD_HIGH:
          prdata_d = read_half(cfg_q.hold, high_w);
        default:
          prdata_d = 32'h00000000;
      endcase
    end
  end

  // registers
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cfg_q <= {`RESET_CFG, `RESET_CFG, `RESET_CFG, `RESET_CFG};
      status_q <= `RESET_STATUS;
      prdata_q <= 32'h00000000;
      irq_q <= 1'b0;
    end
    else
    begin
      cfg_q <= cfg_d;
      status_q <= status_d;
      prdata_q <= prdata_d;
      irq_q <= irq_d;
    end
  end

  // unheld level pins show status exactly when the pin sat at the selected level
  property p_level_polarity;
    @(posedge pclk) disable iff (!presetn)
    clk_en |=> (((status_q ^ ~($past(level_w) ^ $past(cfg_q.polarity))) &
                 ~$past(cfg_q.trigger) & ~$past(cfg_q.hold)) == '0);
  endproperty
  a_level_polarity: assert property (p_level_polarity) else $error("level condition wrong");

  // any change on an edge pin raises its status, whatever the polarity
  property p_edge_any_change;
    @(posedge pclk) disable iff (!presetn)
    clk_en |=> ((($past(level_w) ^ $past(prev_w)) & $past(cfg_q.trigger) & ~status_q) == '0);
  endproperty
  a_edge_any_change: assert property (p_edge_any_change) else $error("edge condition wrong");

  // a held request survives until a clear
  property p_hold_keeps;
    @(posedge pclk) disable iff (!presetn)
    clk_en |=> ((~status_q & $past(keep_w)) == '0);
  endproperty
  a_hold_keeps: assert property (p_hold_keeps) else $error("held request lost");

  // through pins mirror the last condition
  property p_through_follows;
    @(posedge pclk) disable iff (!presetn)
    clk_en |=> (((status_q ^ $past(cond_w)) & $past(thru_w)) == '0);
  endproperty
  a_through_follows: assert property (p_through_follows) else $error("through not followed");

  // a write of one clears a held bit with no new condition
  property p_clear_write;
    @(posedge pclk) disable iff (!presetn)
    clk_en |=> ((status_q & $past(cleared_w)) == '0);
  endproperty
  a_clear_write: assert property (p_clear_write) else $error("status not cleared");

  // hold pins latch even while disabled
  property p_latch_disabled;
    @(posedge pclk) disable iff (!presetn)
    clk_en |=> ((~status_q & $past(latch_w)) == '0);
  endproperty
  a_latch_disabled: assert property (p_latch_disabled) else $error("request not latched");

  // a pending unmasked request raises irq one edge later
  property p_unmask_delivers;
    @(posedge pclk) disable iff (!presetn)
    (clk_en && (pend_w != '0)) |=> irq_q;
  endproperty
  a_unmask_delivers: assert property (p_unmask_delivers) else $error("irq not raised");

  // nothing unmasked pending keeps irq low
  property p_masked_quiet;
    @(posedge pclk) disable iff (!presetn)
    (clk_en && (pend_w == '0)) |=> !irq_q;
  endproperty
  a_masked_quiet: assert property (p_masked_quiet) else $error("irq while masked");

  // upper registers read back zero above bit four
  property p_reserved_zero;
    @(posedge pclk) disable iff (!presetn)
    (psel && penable && high_w) |-> (prdata_q[31:`HIGH_PIN_COUNT] == '0);
  endproperty
  a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bits set");

endmodule

`default_nettype wire

// ---- tb/pin_source.sv ----
// far-side model: drives the 21 pin levels seen by the block
// assumes pclk from the bench; pins idle high and change just after a rising edge
`timescale 1ns/10ps
`default_nettype none
`include "gpio_irq_cfg.svh"

module pin_source (
  input wire logic pclk,
  output logic [`PIN_COUNT-1:0] pins
);
  int seed = 32'h1D141553;

  // pins start high so low-active level pins stay quiet after reset
  initial pins = '1;

  // move one pin, promptly or after a few idle cycles
  task automatic drive(input int p, input logic v);
    int d;
    d = $unsigned($random(seed)) % 4;
    repeat (d) @(posedge pclk);
    @(posedge pclk);
    pins[p] <= v;
  endtask
endmodule
`default_nettype wire

// ---- tb/gpio_interrupt_condition_tb.sv ----
// self-checking bench for the pin interrupt condition block, with a register model
// assumes the design and pin_source are compiled first and the config header is on the path
`timescale 1ns/10ps
`default_nettype none
`include "gpio_irq_cfg.svh"

module gpio_interrupt_condition_tb;
  localparam logic [11:0] A_ST_L = {`IDX_STATUS_LOW, 2'b00};
  localparam logic [11:0] A_ST_H = {`IDX_STATUS_HIGH, 2'b00};
  localparam logic [11:0] A_EN_L = {`IDX_ENABLE_LOW, 2'b00};
  localparam logic [11:0] A_TR_L = {`IDX_TRIG_LOW, 2'b00};
  localparam logic [11:0] A_PO_L = {`IDX_POL_LOW, 2'b00};
  localparam logic [11:0] A_HO_L = {`IDX_HOLD_LOW, 2'b00};
  localparam logic [11:0] CFG_A [8] = '{A_TR_L, A_TR_L + 12'h008, A_PO_L, A_PO_L + 12'h008,
    A_HO_L, A_HO_L + 12'h008, A_EN_L, A_EN_L + 12'h008};
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic clk_en = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [3:0] pstrb = 4'hF;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [`PIN_COUNT-1:0] gpio_in;
  logic irq;
  int miscompares = 0;
  int checks = 0;
  int seed = 32'h1D141553;
  int mdl [int];
  logic [31:0] rd;
  logic err;
  logic [20:0] b;
  int p;

  // 50 MHz clock
  always
  begin
    #10;
    pclk = ~pclk;
  end

  gpio_interrupt_condition u_dut (.pclk(pclk), .presetn(presetn), .clk_en(clk_en),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .gpio_in(gpio_in), .irq(irq));
  pin_source u_pins (.pclk(pclk), .pins(gpio_in));

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic stop_test();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // one apb transfer; stall holds clk_en low for that many access cycles
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, input int stall);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    if (stall > 0)
      clk_en <= 1'b0;
    // no cycle limit of its own: a missing ready is left to the watchdog
    do
    begin
      @(posedge pclk);
      n++;
      if (n == stall)
        clk_en <= 1'b1;
    end
    while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // write with random stall; model keeps 16 bits low, 5 bits high (addr bit 3 set)
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d, $unsigned($random(seed)) % 3);
    if (mdl.exists(a))
      mdl[a] = d & (a[3] ? 32'h1F : 32'hFFFF);
  endtask

  task automatic rdr(input logic [11:0] a);
    apb(1'b0, a, 32'h0, 0);
  endtask

  task automatic setv(input logic [11:0] al, input logic [20:0] v);
    wr(al, {16'h0, v[15:0]});
    wr(al + 12'h008, {27'h0, v[20:16]});
  endtask

  task automatic stchk(input logic [20:0] exp);
    rdr(A_ST_L);
    check(rd, {16'h0, exp[15:0]});
    rdr(A_ST_H);
    check(rd, {27'h0, exp[20:16]});
  endtask

  task automatic settle(input int n);
    repeat (n) @(posedge pclk);
  endtask

  task automatic irqchk(input logic v);
    check({31'h0, irq}, {31'h0, v});
  endtask

  // watchdog against a hung handshake
  initial
  begin
    #1000000;
    miscompares++;
    $display("BAD t=%0t watchdog expired", $time);
    stop_test();
  end

  // main sequence
  initial
  begin
    for (int i = 0; i < 8; i++)
      mdl[CFG_A[i]] = 0;
    settle(4);
    presetn <= 1'b1;
    settle(12);
    for (int i = 0; i < 8; i++)
    begin
      rdr(CFG_A[i]);
      check(rd, 32'h0);
    end
    // random read-back; enables stay 0 so edge+through is never unmasked
    for (int i = 0; i < 6; i++)
    begin
      wr(CFG_A[i], $random(seed));
      rdr(CFG_A[i]);
      check(rd, mdl[CFG_A[i]]);
      wr(CFG_A[i], 32'h0);
    end
    pstrb <= 4'h2;
    wr(A_PO_L, 32'h0000FFFF);
    pstrb <= 4'hF;
    rdr(A_PO_L);
    check(rd, 32'h0000FF00);
    wr(A_PO_L, 32'h0);
    apb(1'b0, 12'h004, 32'h0, 0);
    check({31'h0, err}, 32'h1);
    check(rd, 32'h0);
    wr(A_ST_L, 32'hFFFF);
    wr(A_ST_H, 32'h1F);
    for (int k = 0; k < 2; k++)
    begin
      p = k ? 16 + $unsigned($random(seed)) % 5 : $unsigned($random(seed)) % 16;
      b = 21'h1 << p;
      // level, high active, hold, masked; trigger stays level
      u_pins.drive(p, 1'b0);
      settle(8);
      setv(A_HO_L, b);
      setv(A_PO_L, b);
      wr(A_ST_L, 32'hFFFF);
      wr(A_ST_H, 32'h1F);
      settle(8);
      stchk(21'h0);
      u_pins.drive(p, 1'b1);
      settle(8);
      stchk(b);
      irqchk(1'b0);
      u_pins.drive(p, 1'b0);
      settle(8);
      stchk(b);
      setv(A_EN_L, b);
      settle(3);
      rdr(A_EN_L + {11'h0, k[0]} * 12'h008);
      check(rd, k ? {27'h0, b[20:16]} : {16'h0, b[15:0]});
      irqchk(1'b1);
      wr(A_ST_L, 32'hFFFF);
      wr(A_ST_H, 32'h1F);
      settle(3);
      stchk(21'h0);
      irqchk(1'b0);
      // through, low active: follows the pin, no replay on unmask
      setv(A_EN_L, 21'h0);
      setv(A_HO_L, 21'h0);
      setv(A_PO_L, 21'h0);
      settle(8);
      stchk(b);
      irqchk(1'b0);
      u_pins.drive(p, 1'b1);
      settle(8);
      stchk(21'h0);
      setv(A_EN_L, b);
      settle(3);
      irqchk(1'b0);
      u_pins.drive(p, 1'b0);
      settle(8);
      irqchk(1'b1);
      u_pins.drive(p, 1'b1);
      settle(8);
      irqchk(1'b0);
      setv(A_EN_L, 21'h0);
      // edge, hold, either polarity; edge is never left through and unmasked
      for (int pv = 0; pv < 2; pv++)
      begin
        setv(A_TR_L, b);
        setv(A_HO_L, b);
        setv(A_PO_L, pv ? b : 21'h0);
        settle(8);
        wr(A_ST_L, 32'hFFFF);
        wr(A_ST_H, 32'h1F);
        setv(A_EN_L, b);
        settle(8);
        stchk(21'h0);
        u_pins.drive(p, 1'b0);
        settle(8);
        stchk(b);
        irqchk(1'b1);
        wr(A_ST_L, 32'hFFFF);
        wr(A_ST_H, 32'h1F);
        settle(3);
        irqchk(1'b0);
        u_pins.drive(p, 1'b1);
        settle(8);
        stchk(b);
        setv(A_EN_L, 21'h0);
        setv(A_HO_L, 21'h0);
        setv(A_TR_L, 21'h0);
        setv(A_PO_L, 21'h0);
      end
    end
    settle(4);
    stop_test();
  end
endmodule
`default_nettype wire
